// >>> src/pcsi_pkg.sv
package pcsi_pkg;
	// widths
	localparam int PC_W = 13;
	localparam int PCL_W = 8;
	localparam int PCH_W = 5;
	localparam int OPND_W = 11;
	localparam int EA_W = 9;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int STACK_DEPTH = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_PC_LOW = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_PC_LATCH = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_FILE_PTR = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_BANK = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_IND_PORT = 3'h4;

	// field positions
	localparam int BANK_BIT_POS = 7;
	localparam int LATCH_TOP_HI = 4;
	localparam int LATCH_TOP_LO = 3;

	// reset values and other constants
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PCH_W-1:0] LATCH_RESET = 5'h00;
	localparam logic [DATA_W-1:0] FSR_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [6:0] IND_SELF_LOW = 7'h00;

	// sequencing commands
	typedef enum logic [2:0] {
		PCSI_CMD_HOLD = 3'b000,
		PCSI_CMD_STEP = 3'b001,
		PCSI_CMD_JUMP = 3'b010,
		PCSI_CMD_CALL = 3'b011,
		PCSI_CMD_RET = 3'b100,
		PCSI_CMD_RETLIT = 3'b101,
		PCSI_CMD_RETINT = 3'b110,
		PCSI_CMD_INTVEC = 3'b111
	} pcsi_cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pcsi_bus_t;

	typedef struct packed {
		pcsi_cmd_t cmd;
		logic [OPND_W-1:0] operand;
	} pcsi_seq_t;
endpackage

// >>> src/pcsi_core.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - program counter is 13 bits; its low byte is software readable and writable.
// - counter bits 12..8 are hidden from software; a low-byte write loads them from the latch.
// - every reset clears the whole program counter.
// - writing the low byte loads latch bits 4..0 into the high bits together.
// - call or jump takes the two top counter bits from latch bits 4..3.
// - eight-entry 13-bit return stack, pointer invisible to software.
// - call or interrupt vectoring pushes the current program counter.
// - return, return with literal and interrupt return pop into the counter.
// - push and pop leave the latch untouched.
// - stack is circular; the ninth push overwrites the first entry.
// - no overflow or underflow flag or trap exists.
// - indirect port holds nothing; it reaches the location the pointer selects.
// - indirect read through a pointer aimed at the port itself gives zero.
// - indirect write through a pointer aimed at the port itself stores nothing.
// - indirect address is the bank bit above the 8-bit pointer, 9 bits.
module pcsi_core
	import pcsi_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter logic [PC_W-1:0] INT_VECTOR = 13'h0004
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register port
	input wire pcsi_bus_t bus_req,
	output logic [DATA_W-1:0] rd_data,
	// instruction sequencing
	input wire pcsi_seq_t seq_req,
	output logic [PC_W-1:0] pc,
	// data space reached by the indirect port
	output logic [EA_W-1:0] mem_addr,
	output logic mem_we,
	output logic [DATA_W-1:0] mem_wdata,
	input wire logic [DATA_W-1:0] mem_rdata
);
	localparam int SP_W = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("stack depth must be a power of two, at least 2");
	end

	function automatic logic ind_self(input logic [DATA_W-1:0] ptr);
		// the port is mirrored in every bank, so only the low seven bits matter
		return ptr[6:0] == IND_SELF_LOW;
	endfunction

	logic rst_meta_n;
	logic rst_n;
	logic [PCH_W-1:0] pc_high_latch;
	logic [DATA_W-1:0] file_pointer_reg;
	logic bank_pointer_bit;
	logic [SP_W-1:0] sp;
	logic [PC_W-1:0] stack_mem [DEPTH];

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// bus decode
	wire wr_pcl = bus_req.wr && bus_req.addr == OFS_PC_LOW;
	wire wr_latch = bus_req.wr && bus_req.addr == OFS_PC_LATCH;
	wire wr_fsr = bus_req.wr && bus_req.addr == OFS_FILE_PTR;
	wire wr_bank = bus_req.wr && bus_req.addr == OFS_BANK;
	wire wr_ind = bus_req.wr && bus_req.addr == OFS_IND_PORT;
	wire rd_ind = bus_req.rd && bus_req.addr == OFS_IND_PORT;
	wire self_ptr = ind_self(file_pointer_reg);

	// sequencing decode; a low-byte write is the instruction's own result and wins
	wire is_jump = seq_req.cmd == PCSI_CMD_JUMP;
	wire is_call = seq_req.cmd == PCSI_CMD_CALL;
	wire is_int = seq_req.cmd == PCSI_CMD_INTVEC;
	wire is_pop = seq_req.cmd == PCSI_CMD_RET || seq_req.cmd == PCSI_CMD_RETLIT
		|| seq_req.cmd == PCSI_CMD_RETINT;
	wire do_push = !wr_pcl && (is_call || is_int);
	wire do_pop = !wr_pcl && is_pop;
	wire [SP_W-1:0] sp_dec = SP_W'(sp - 1'b1);
	wire [PC_W-1:0] top_entry = stack_mem[sp_dec];
	wire [PC_W-1:0] far_target = {pc_high_latch[LATCH_TOP_HI:LATCH_TOP_LO],
		seq_req.operand};

	logic [PC_W-1:0] next_pc;
	always_comb
	begin
		next_pc = pc;
		if (wr_pcl)
			next_pc = {pc_high_latch, bus_req.wdata};
		else if (is_jump || is_call)
			next_pc = far_target;
		else if (is_int)
			next_pc = INT_VECTOR;
		else if (do_pop)
			next_pc = top_entry;
		else if (seq_req.cmd == PCSI_CMD_STEP)
			next_pc = PC_W'(pc + PC_ONE);
	end

	wire [DATA_W-1:0] next_fsr = wr_fsr ? bus_req.wdata : file_pointer_reg;
	wire next_bank = wr_bank ? bus_req.wdata[BANK_BIT_POS] : bank_pointer_bit;

	// read mux; the high counter bits and the stack pointer have no read path
	logic [DATA_W-1:0] next_rd;
	always_comb
	begin
		case (bus_req.addr)
			OFS_PC_LOW: next_rd = pc[PCL_W-1:0];
			OFS_PC_LATCH: next_rd = {3'b000, pc_high_latch};
			OFS_FILE_PTR: next_rd = file_pointer_reg;
			OFS_BANK: next_rd = {bank_pointer_bit, 7'b000_0000};
			OFS_IND_PORT: next_rd = self_ptr ? READ_ZERO : mem_rdata;
			default: next_rd = READ_ZERO;
		endcase
		if (!bus_req.rd)
			next_rd = READ_ZERO;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pc <= PC_RESET;
			pc_high_latch <= LATCH_RESET;
			file_pointer_reg <= FSR_RESET;
			bank_pointer_bit <= 1'b0;
			sp <= '0;
			rd_data <= READ_ZERO;
			mem_addr <= '0;
			mem_we <= 1'b0;
			mem_wdata <= READ_ZERO;
		end
		else
		begin
			pc <= next_pc;
			// only a bus write touches the latch, never a push or pop
			if (wr_latch)
				pc_high_latch <= bus_req.wdata[PCH_W-1:0];
			file_pointer_reg <= next_fsr;
			bank_pointer_bit <= next_bank;
			mem_addr <= {next_bank, next_fsr};
			// wrap is silent, nothing flags it
			if (do_push)
				sp <= SP_W'(sp + 1'b1);
			else if (do_pop)
				sp <= sp_dec;
			rd_data <= next_rd;
			mem_we <= wr_ind && !self_ptr;
			mem_wdata <= wr_ind ? bus_req.wdata : mem_wdata;
		end
	end

	// stack storage has no reset: stale entries are what an empty pop returns
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_stack
			always_ff @(posedge sys_clk)
			begin
				if (do_push && sp == SP_W'(gi))
					stack_mem[gi] <= pc;
			end
		end
	endgenerate

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence pcl_write_s;
		wr_pcl;
	endsequence

	sequence pc_joined_s(logic [PCH_W-1:0] hi, logic [DATA_W-1:0] lo);
		pc == {hi, lo};
	endsequence

	pcl_full_load_a: assert property (pcl_write_s |=>
		pc_joined_s($past(pc_high_latch), $past(bus_req.wdata)))
		else $error("low byte write did not load all counter bits");

	far_target_a: assert property ((is_jump || is_call) && !wr_pcl |=>
		pc == {$past(pc_high_latch[LATCH_TOP_HI:LATCH_TOP_LO]), $past(seq_req.operand)})
		else $error("jump or call target wrong");

	push_store_a: assert property (do_push |=>
		stack_mem[$past(sp)] == $past(pc) && sp == SP_W'($past(sp) + 1'b1))
		else $error("push did not store counter");

	pop_load_a: assert property (do_pop |=> pc == $past(top_entry) && sp == $past(sp_dec))
		else $error("pop did not restore counter");

	latch_keep_a: assert property ((do_push || do_pop) && !wr_latch |=>
		$stable(pc_high_latch))
		else $error("stack action changed latch");

	circ_wrap_a: assert property (do_push && sp == SP_W'(DEPTH - 1) |=> sp == '0)
		else $error("stack pointer did not wrap");

	self_read_a: assert property (rd_ind && self_ptr |=> rd_data == READ_ZERO)
		else $error("self pointed read not zero");

	self_write_a: assert property (wr_ind && self_ptr |=> !mem_we)
		else $error("self pointed write stored data");

	ind_addr_a: assert property (##1 mem_addr == {bank_pointer_bit, file_pointer_reg})
		else $error("indirect address not bank over pointer");

	// back to back indirect writes are legal, so the pulse may stay high
	ind_write_a: assert property (wr_ind && !self_ptr |=> mem_we)
		else $error("indirect write pulse wrong");

	no_write_a: assert property (!wr_ind |=>
		!mem_we)
		else $error("data space written without indirect write");

	ind_data_a: assert property (wr_ind && !self_ptr |=>
		mem_wdata == $past(bus_req.wdata))
		else $error("indirect write data wrong");

	ind_read_a: assert property (rd_ind && !self_ptr |=>
		rd_data == $past(mem_rdata))
		else $error("indirect read data wrong");

	step_inc_a: assert property (seq_req.cmd == PCSI_CMD_STEP && !wr_pcl |=>
		pc == PC_W'($past(pc) + PC_ONE))
		else $error("step did not advance counter");

	hold_keep_a: assert property (seq_req.cmd == PCSI_CMD_HOLD && !wr_pcl |=>
		$stable(pc))
		else $error("counter moved on hold");

	pcl_read_a: assert property (bus_req.rd && bus_req.addr == OFS_PC_LOW |=>
		rd_data == $past(pc[PCL_W-1:0]))
		else $error("low byte read wrong");

	rd_idle_a: assert property (!bus_req.rd |=>
		rd_data == READ_ZERO)
		else $error("read data not zero outside read");

	latch_read_a: assert property (bus_req.rd && bus_req.addr == OFS_PC_LATCH |=>
		rd_data == {3'b000, $past(pc_high_latch)})
		else $error("latch read wrong");

	latch_write_a: assert property (wr_latch |=>
		pc_high_latch == $past(bus_req.wdata[PCH_W-1:0]))
		else $error("latch write wrong");

	latch_only_a: assert property (wr_latch && seq_req.cmd == PCSI_CMD_HOLD |=>
		$stable(pc))
		else $error("latch write moved counter");

	far_low_a: assert property ((is_jump || is_call) && !wr_pcl |=>
		pc[OPND_W-1:0] == $past(seq_req.operand))
		else $error("jump or call low bits wrong");

	pcl_no_stack_a: assert property (wr_pcl |=>
		sp == $past(sp))
		else $error("low byte write moved stack");

	int_vector_a: assert property (is_int && !wr_pcl |=>
		pc == INT_VECTOR)
		else $error("interrupt did not vector");

	int_push_a: assert property (is_int && !wr_pcl |=>
		stack_mem[$past(sp)] == $past(pc))
		else $error("interrupt did not push counter");

	sp_keep_a: assert property (!do_push && !do_pop |=>
		$stable(sp))
		else $error("stack pointer moved without push or pop");

	unmapped_rd_a: assert property (bus_req.rd && bus_req.addr > OFS_IND_PORT |=>
		rd_data == READ_ZERO)
		else $error("unmapped read not zero");

	pop_wrap_a: assert property (do_pop && sp == '0 |=>
		sp == SP_W'(DEPTH - 1))
		else $error("empty pop did not wrap");

	fsr_write_a: assert property (wr_fsr |=>
		file_pointer_reg == $past(bus_req.wdata))
		else $error("pointer write wrong");

	bank_write_a: assert property (wr_bank |=>
		bank_pointer_bit == $past(bus_req.wdata[BANK_BIT_POS]))
		else $error("bank bit write wrong");
endmodule

// >>> tb/pcsi_core_tb.sv
`timescale 1ns/1ps
module pcsi_core_tb;
	import pcsi_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	pcsi_bus_t bus_req = '0;
	pcsi_seq_t seq_req = '0;
	logic [DATA_W-1:0] rd_data;
	logic [PC_W-1:0] pc;
	logic [EA_W-1:0] mem_addr;
	logic mem_we;
	logic [DATA_W-1:0] mem_wdata;
	wire logic [DATA_W-1:0] mem_rdata;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [PC_W-1:0] stk [0:8];
	pcsi_cmd_t rets [0:2] = '{PCSI_CMD_RET, PCSI_CMD_RETLIT, PCSI_CMD_RETINT};

	always #5 sys_clk = ~sys_clk;
	// data space stand-in: value depends on address bits 7..0 so a wrong pointer shows; the bank bit does not enter
	assign mem_rdata = mem_addr[7:0] ^ 8'hA5;

	pcsi_core uut (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.seq_req(seq_req),
		.pc(pc),
		.mem_addr(mem_addr),
		.mem_we(mem_we),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata)
	);

	task automatic chk_dat(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t data got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t counter got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge sys_clk);
		bus_req <= '0;
		#1;
	endtask

	task automatic seq(input pcsi_cmd_t c, input logic [OPND_W-1:0] op);
		@(posedge sys_clk);
		seq_req <= '{cmd: c, operand: op};
		@(posedge sys_clk);
		seq_req <= '0;
		#1;
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ceiling well above the fewer than a hundred cycles the tests need
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			failures++;
			$display("ERROR %0t timeout", $time);
			wrap_up();
		end
	end

	initial
	begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk_pc(pc, 13'h0000);
		bus(OFS_PC_LATCH, 8'hff, 1'b1);
		bus(OFS_PC_LOW, 8'h34, 1'b1);
		chk_pc(pc, 13'h1f34);
		bus(OFS_PC_LOW, 8'h00, 1'b0);
		chk_dat(rd_data, 8'h34);
		@(posedge sys_clk);
		#1;
		chk_dat(rd_data, 8'h00);
		bus(OFS_PC_LATCH, 8'h0a, 1'b1);
		chk_pc(pc, 13'h1f34);
		bus(OFS_PC_LOW, 8'hff, 1'b1);
		chk_pc(pc, 13'h0aff);
		// table rollover: software must bump the latch, the low byte write never carries
		bus(OFS_PC_LOW, 8'h00, 1'b1);
		chk_pc(pc, 13'h0a00);
		bus(OFS_PC_LATCH, 8'h0b, 1'b1);
		bus(OFS_PC_LOW, 8'h00, 1'b1);
		chk_pc(pc, 13'h0b00);
		bus(OFS_PC_LATCH, 8'h0a, 1'b1);
		seq(PCSI_CMD_JUMP, 11'h123);
		chk_pc(pc, 13'h0923);
		seq(PCSI_CMD_STEP, 11'h000);
		chk_pc(pc, 13'h0924);
		$display("test counter done");
		// eight calls fill the stack, the interrupt push wraps onto slot 0
		stk[0] = 13'h0924;
		for (int i = 0; i < 8; i++)
		begin
			seq(PCSI_CMD_CALL, 11'h010 + 11'(i));
			stk[i + 1] = {2'b01, 11'h010 + 11'(i)};
			chk_pc(pc, stk[i + 1]);
		end
		seq(PCSI_CMD_INTVEC, 11'h000);
		chk_pc(pc, 13'h0004);
		for (int j = 0; j < 9; j++)
		begin
			seq(rets[j % 3], 11'h000);
			chk_pc(pc, stk[(j == 0 || j == 8) ? 8 : 8 - j]);
		end
		bus(OFS_PC_LATCH, 8'h00, 1'b0);
		chk_dat(rd_data, 8'h0a);
		$display("test stack done");
		bus(OFS_FILE_PTR, 8'h25, 1'b1);
		bus(OFS_BANK, 8'h80, 1'b1);
		bus(OFS_IND_PORT, 8'h00, 1'b0);
		chk_dat(rd_data, 8'h80);
		chk_pc({4'h0, mem_addr}, 13'h0125);
		bus(OFS_IND_PORT, 8'h5a, 1'b1);
		chk_dat({mem_we, mem_wdata[6:0]}, 8'hda);
		bus(OFS_FILE_PTR, 8'h80, 1'b1);
		bus(OFS_IND_PORT, 8'h77, 1'b1);
		chk_dat({7'h00, mem_we}, 8'h00);
		bus(OFS_IND_PORT, 8'h00, 1'b0);
		chk_dat(rd_data, 8'h00);
		$display("test indirect done");
		reset_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk_pc(pc, 13'h0000);
		$display("test reset done");
		wrap_up();
	end
endmodule
